// File: verilog/spc_serial_cfg_defs.vh
// constants for the serial port configuration register bank
`ifndef SPC_SERIAL_CFG_DEFS_VH
`define SPC_SERIAL_CFG_DEFS_VH

// register address space
`define SPC_ADDR_W      13
`define SPC_OFS_CFG     13'h000
`define SPC_OFS_RBS     13'h004

// serial port configuration fields
`define SPC_CFG_DIR     7
`define SPC_CFG_LSB     6
`define SPC_CFG_SRST    5
`define SPC_CFG_MIR_HI  3
`define SPC_CFG_MIR_LO  0

// readback bank select field
`define SPC_RBS_SEL     0

// reset values
`define SPC_CFG_DIR_RST 1'b0
`define SPC_CFG_LSB_RST 1'b0
`define SPC_CFG_MIR_RST 4'h0
`define SPC_RBS_RST     1'b0

// read value of an unmapped address
`define SPC_RD_NONE     8'h00

// instruction word layout and bit counts
`define SPC_INSTR_W     16
`define SPC_RW_BIT      15
`define SPC_ADDR_HI     12
`define SPC_INSTR_LAST  4'hF
`define SPC_BYTE_LAST   4'h7
`define SPC_CNT_FIRST   4'h1
`define SPC_CNT_ZERO    4'h0
`define SPC_ADDR_STEP   13'h0001

`endif

// File: verilog/spc_shift_in.v
// serial input shifter with selectable bit order
module spc_shift_in #(
  parameter WIDTH = 16
) (
  // clock, reset and enable
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  // control
  input  wire             clr,
  input  wire             shift_en,
  input  wire             lsb_first,
  // data
  input  wire             bit_in,
  output wire [WIDTH-1:0] word_nxt
);

  reg  [WIDTH-1:0] word_ff;   // bits gathered so far

  // msb first enters at the bottom, lsb first enters at the top
  assign word_nxt = lsb_first ? {bit_in, word_ff[WIDTH-1:1]}
                              : {word_ff[WIDTH-2:0], bit_in};

  // shift register, cleared between transfers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (clr) begin
        word_ff <= {WIDTH{1'b0}};
      end else if (shift_en) begin
        word_ff <= word_nxt;
      end
    end
  end

endmodule // spc_shift_in

// File: verilog/spc_serial_cfg.v
// serial control port engine with port configuration and readback select
//
// Notes on behaviour
// RQ1: bit7 low: shared data pin, output pin floats
// RQ2: bit7 high: read data only on output pin
// RQ3: bit6 low: msb first, address decrements
// RQ4: bit6 high: lsb first, address increments
// RQ5: bit order ignored in i2c mode
// RQ6: soft reset restores defaults, clears itself
// RQ7: host writes low nibble mirroring high nibble
// RQ8: readback select picks buffer or active copy
// RQ9: new format applies after the transfer ends
`include "spc_serial_cfg_defs.vh"

module spc_serial_cfg (
  // clock, reset, enable
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  // serial port pins
  input  wire csb_n,
  input  wire sclk,
  input  wire sdio_in,
  output wire sdio_out,
  output wire sdio_oe,
  output wire serial_out_pin,
  output wire serial_out_oe,
  // mode and transfer control
  input  wire i2c_mode,
  input  wire reg_update,
  // status towards the rest of the chip
  output wire pin_direction_select,
  output wire lsb_first_act,
  output wire soft_reset_pulse
);

  // one-hot transfer states
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_INSTR = 4'h2;
  localparam [3:0] ST_WDATA = 4'h4;
  localparam [3:0] ST_RDATA = 4'h8;

  reg  [3:0]             state_ff;     // transfer state
  reg  [3:0]             cnt_ff;       // bit counter within field
  reg  [`SPC_ADDR_W-1:0] addr_ff;      // current register address
  reg  [7:0]             tx_ff;        // read byte being shifted out
  reg                    sclk_q_ff;    // sclk one cycle ago
  reg                    csb_q_ff;     // chip select one cycle ago
  reg                    sdio_out_ff;  // shared pin data
  reg                    sdio_oe_ff;   // shared pin enable
  reg                    sdo_out_ff;   // output pin data
  reg                    sdo_oe_ff;    // output pin enable
  reg                    srst_ff;      // soft reset pulse
  // buffer copies
  reg                    cfg_dir_ff;   // pin direction, buffer
  reg                    cfg_lsb_ff;   // bit order, buffer
  reg  [3:0]             cfg_mir_ff;   // mirror nibble, buffer
  reg                    rbs_sel_ff;   // readback select, buffer
  // active copies
  reg                    act_dir_ff;   // pin direction, active
  reg                    act_lsb_ff;   // bit order, active
  reg  [3:0]             act_mir_ff;   // mirror nibble, active
  reg                    act_rbs_ff;   // readback select, active
  // format in force for the serial engine
  reg                    fmt_dir_ff;   // pin direction in use
  reg                    fmt_lsb_ff;   // bit order in use

  wire                   eff_lsb;      // bit order after i2c override
  wire                   sclk_rise;    // sampling edge
  wire                   sclk_fall;    // launch edge
  wire                   cs_end;       // transfer just finished
  wire [`SPC_INSTR_W-1:0] word_nxt;    // shifter content incl. new bit
  wire [7:0]             rx_byte;      // received data byte
  wire [`SPC_ADDR_W-1:0] addr_step;    // next address in a stream
  wire                   tx_bit;       // bit to launch

  // RQ5: i2c ignores order
  assign eff_lsb   = fmt_lsb_ff & ~i2c_mode;
  assign sclk_rise = sclk & ~sclk_q_ff & ~csb_n;
  assign sclk_fall = ~sclk & sclk_q_ff & ~csb_n;
  assign cs_end    = csb_n & ~csb_q_ff;

  // lsb first data lands in the upper half of the shifter
  assign rx_byte = eff_lsb ? word_nxt[`SPC_INSTR_W-1:8] : word_nxt[7:0];

  // RQ3: msb first decrements
  // RQ4: lsb first increments
  assign addr_step = eff_lsb ? addr_ff + `SPC_ADDR_STEP
                             : addr_ff - `SPC_ADDR_STEP;

  assign tx_bit = eff_lsb ? tx_ff[0] : tx_ff[7];

  // pins and status straight from flip-flops
  assign sdio_out             = sdio_out_ff;
  assign sdio_oe              = sdio_oe_ff;
  assign serial_out_pin       = sdo_out_ff;
  assign serial_out_oe        = sdo_oe_ff;
  assign pin_direction_select = fmt_dir_ff;
  assign lsb_first_act        = fmt_lsb_ff;
  assign soft_reset_pulse     = srst_ff;

  // read data for one address
  function [7:0] rd_byte;
    input [`SPC_ADDR_W-1:0] a;
    input                   use_act;
    begin
      rd_byte = `SPC_RD_NONE;
      // RQ8: buffer or active
      if (a == `SPC_OFS_CFG) begin
        rd_byte = use_act ? {act_dir_ff, act_lsb_ff, 2'b00, act_mir_ff}
                          : {cfg_dir_ff, cfg_lsb_ff, 2'b00, cfg_mir_ff};
      end else if (a == `SPC_OFS_RBS) begin
        rd_byte = {7'h00, use_act ? act_rbs_ff : rbs_sel_ff};
      end
    end
  endfunction

  // instruction and data shifter
  spc_shift_in #(
    .WIDTH     (`SPC_INSTR_W)
  ) u_shift (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .clr       (csb_n),
    .shift_en  (sclk_rise & ~state_ff[3]),
    .lsb_first (eff_lsb),
    .bit_in    (sdio_in),
    .word_nxt  (word_nxt)
  );

  // transfer engine and register bank
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= `SPC_CNT_ZERO;
      addr_ff     <= {`SPC_ADDR_W{1'b0}};
      tx_ff       <= 8'h00;
      sclk_q_ff   <= 1'b0;
      csb_q_ff    <= 1'b1;
      sdio_out_ff <= 1'b0;
      sdio_oe_ff  <= 1'b0;
      sdo_out_ff  <= 1'b0;
      sdo_oe_ff   <= 1'b0;
      srst_ff     <= 1'b0;
      cfg_dir_ff  <= `SPC_CFG_DIR_RST;
      cfg_lsb_ff  <= `SPC_CFG_LSB_RST;
      cfg_mir_ff  <= `SPC_CFG_MIR_RST;
      rbs_sel_ff  <= `SPC_RBS_RST;
      act_dir_ff  <= `SPC_CFG_DIR_RST;
      act_lsb_ff  <= `SPC_CFG_LSB_RST;
      act_mir_ff  <= `SPC_CFG_MIR_RST;
      act_rbs_ff  <= `SPC_RBS_RST;
      fmt_dir_ff  <= `SPC_CFG_DIR_RST;
      fmt_lsb_ff  <= `SPC_CFG_LSB_RST;
    end else if (ce) begin
      sclk_q_ff <= sclk;
      csb_q_ff  <= csb_n;
      srst_ff   <= 1'b0;
      // buffer to active transfer
      if (reg_update) begin
        act_dir_ff <= cfg_dir_ff;
        act_lsb_ff <= cfg_lsb_ff;
        act_mir_ff <= cfg_mir_ff;
        act_rbs_ff <= rbs_sel_ff;
      end
      if (csb_n) begin
        // deselected: release both pins
        state_ff   <= ST_IDLE;
        cnt_ff     <= `SPC_CNT_ZERO;
        sdio_oe_ff <= 1'b0;
        sdo_oe_ff  <= 1'b0;
      end else begin
        case (state_ff)
          // first instruction bit
          ST_IDLE: begin
            if (sclk_rise) begin
              state_ff <= ST_INSTR;
              cnt_ff   <= `SPC_CNT_FIRST;
            end
          end
          // gather rw and address
          ST_INSTR: begin
            if (sclk_rise) begin
              if (cnt_ff == `SPC_INSTR_LAST) begin
                addr_ff <= word_nxt[`SPC_ADDR_HI:0];
                cnt_ff  <= `SPC_CNT_ZERO;
                if (word_nxt[`SPC_RW_BIT]) begin
                  state_ff <= ST_RDATA;
                  tx_ff    <= rd_byte(word_nxt[`SPC_ADDR_HI:0], rbs_sel_ff);
                end else begin
                  state_ff <= ST_WDATA;
                end
              end else begin
                cnt_ff <= cnt_ff + `SPC_CNT_FIRST;
              end
            end
          end
          // write bytes, address steps per byte
          ST_WDATA: begin
            if (sclk_rise) begin
              if (cnt_ff == `SPC_BYTE_LAST) begin
                cnt_ff  <= `SPC_CNT_ZERO;
                addr_ff <= addr_step;
                if (addr_ff == `SPC_OFS_CFG) begin
                  if (rx_byte[`SPC_CFG_SRST]) begin
                    // RQ6: defaults, self-clearing
                    srst_ff    <= 1'b1;
                    cfg_dir_ff <= `SPC_CFG_DIR_RST;
                    cfg_lsb_ff <= `SPC_CFG_LSB_RST;
                    cfg_mir_ff <= `SPC_CFG_MIR_RST;
                    rbs_sel_ff <= `SPC_RBS_RST;
                    act_dir_ff <= `SPC_CFG_DIR_RST;
                    act_lsb_ff <= `SPC_CFG_LSB_RST;
                    act_mir_ff <= `SPC_CFG_MIR_RST;
                    act_rbs_ff <= `SPC_RBS_RST;
                  end else begin
                    // RQ7: mirror stored as written
                    cfg_dir_ff <= rx_byte[`SPC_CFG_DIR];
                    cfg_lsb_ff <= rx_byte[`SPC_CFG_LSB];
                    cfg_mir_ff <= rx_byte[`SPC_CFG_MIR_HI:`SPC_CFG_MIR_LO];
                  end
                end else if (addr_ff == `SPC_OFS_RBS) begin
                  rbs_sel_ff <= rx_byte[`SPC_RBS_SEL];
                end
              end else begin
                cnt_ff <= cnt_ff + `SPC_CNT_FIRST;
              end
            end
          end
          // read bytes, launch on falling sclk
          ST_RDATA: begin
            if (sclk_fall) begin
              tx_ff <= eff_lsb ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
              if (fmt_dir_ff) begin
                // RQ2: read on output pin
                sdo_out_ff <= tx_bit;
                sdo_oe_ff  <= 1'b1;
                sdio_oe_ff <= 1'b0;
              end else begin
                // RQ1: read on shared pin
                sdio_out_ff <= tx_bit;
                sdio_oe_ff  <= 1'b1;
                sdo_oe_ff   <= 1'b0;
              end
            end
            if (sclk_rise) begin
              if (cnt_ff == `SPC_BYTE_LAST) begin
                cnt_ff  <= `SPC_CNT_ZERO;
                addr_ff <= addr_step;
                tx_ff   <= rd_byte(addr_step, rbs_sel_ff);
              end else begin
                cnt_ff <= cnt_ff + `SPC_CNT_FIRST;
              end
            end
          end
          default: begin
            state_ff <= ST_IDLE;
            cnt_ff   <= `SPC_CNT_ZERO;
          end
        endcase
      end
      // RQ9: format after transfer
      if (cs_end) begin
        fmt_dir_ff <= cfg_dir_ff;
        fmt_lsb_ff <= cfg_lsb_ff;
      end
    end
  end

endmodule // spc_serial_cfg

// File: verif/spc_serial_cfg_assertions.sv
// port assertions for the serial port configuration bank
module spc_serial_cfg_chk (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial pins
  input wire csb_n,
  input wire sclk,
  input wire sdio_out,
  input wire sdio_oe,
  input wire serial_out_oe,
  // status outputs
  input wire pin_direction_select,
  input wire lsb_first_act,
  input wire soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_OUT_HIZ: assert property (!pin_direction_select |-> !serial_out_oe)
    else $error("output pin driven in shared mode");
  AST_UNI_SDIO: assert property (pin_direction_select |-> !sdio_oe)
    else $error("shared pin driven in split mode");
  AST_OE_IDLE: assert property (csb_n [*3] |-> !sdio_oe && !serial_out_oe)
    else $error("pin driven while deselected");
  AST_BIT_HOLD: assert property (sdio_oe && $past(sdio_oe)
    && !$stable(sdio_out) |-> !$past(sclk)) else $error("read bit moved early");
  AST_SRST_1CYC: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  AST_SRST_XFER: assert property (soft_reset_pulse |-> !csb_n)
    else $error("soft reset outside transfer");
  AST_SRST_DFLT: assert property (soft_reset_pulse |-> ##[1:200]
    (csb_n && !pin_direction_select && !lsb_first_act))
    else $error("format not back to default");
  AST_FMT_AFTER: assert property (!$stable(pin_direction_select)
    || !$stable(lsb_first_act) |-> csb_n && $past(csb_n))
    else $error("format changed inside transfer");
  // main scenarios reached
  cover property (soft_reset_pulse);
  cover property (serial_out_oe);
  cover property (lsb_first_act && sdio_oe);
endmodule // spc_serial_cfg_chk

bind spc_serial_cfg spc_serial_cfg_chk u_chk (
  .clk(clk), .rst_n(rst_n), .csb_n(csb_n), .sclk(sclk), .sdio_out(sdio_out),
  .sdio_oe(sdio_oe), .serial_out_oe(serial_out_oe),
  .pin_direction_select(pin_direction_select),
  .lsb_first_act(lsb_first_act), .soft_reset_pulse(soft_reset_pulse));

// File: verif/spc_host.sv
// host controller model for the serial control port
module spc_host (
  // clock
  input  wire  clk,
  // serial pins
  output logic csb_n,
  output logic sclk,
  output logic sdio_drv,
  input  wire  sdio_out,
  input  wire  serial_out_pin,
  input  wire  pin_dir
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    csb_n = 1'b1;
    sclk = 1'b0;
    sdio_drv = 1'b0;
  end
  // one bit: fall with data, sample read pin, rise
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk) begin
      sclk <= 1'b0;
      sdio_drv <= b;
    end
    repeat (3) @(posedge clk);
    @(negedge clk) r = pin_dir ? serial_out_pin : sdio_out;
    @(posedge clk) sclk <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // whole transfer: instruction then nb bytes, byte 0 in bits 15:8
  task automatic xfer(input logic [15:0] ins, input logic [15:0] wd,
                      input int nb, input logic lsb, output logic [15:0] rd);
    logic r;
    int p;
    rd = 16'h0000;
    @(posedge clk) csb_n <= 1'b0;
    for (int i = 0; i < 16; i++) bit_io(lsb ? ins[i] : ins[15-i], r);
    for (int i = 0; i < 8 * nb; i++) begin
      p = 8 * (1 - i / 8) + (lsb ? i % 8 : 7 - i % 8);
      // released line toggles during read data
      bit_io(ins[15] ? ~sdio_drv : wd[p], r);
      rd[p] = r;
    end
    repeat (2) @(posedge clk);
    @(posedge clk) csb_n <= 1'b1;
    @(posedge clk) sclk <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule // spc_host

// File: verif/tb_spc_serial_cfg.sv
// self-checking bench for the serial port configuration bank
`include "spc_serial_cfg_defs.vh"
module tb_spc_serial_cfg;
  timeunit 1ns;
  timeprecision 1ns;
  // clock, reset and controls
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        i2c_mode = 1'b0;
  logic        reg_update = 1'b0;
  logic [15:0] rd;
  logic        srst_seen = 1'b0;
  int          n_fail = 0;
  int          samples_checked = 0;
  // pins between host and device
  wire csb_n, sclk, sdio_drv, sdio_out, sdio_oe, serial_out_pin, serial_out_oe;
  wire pin_direction_select, lsb_first_act, soft_reset_pulse;
  wire sdio_in = sdio_oe ? sdio_out : sdio_drv;
  // released output pin shows the inverse of its last value
  wire sdo_line = serial_out_oe ? serial_out_pin : ~serial_out_pin;
  always #10 clk = ~clk;
  // remember a soft reset pulse
  always @(posedge clk) if (soft_reset_pulse === 1'b1) srst_seen <= 1'b1;
  spc_serial_cfg u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .csb_n(csb_n),
    .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .i2c_mode(i2c_mode), .reg_update(reg_update),
    .pin_direction_select(pin_direction_select),
    .lsb_first_act(lsb_first_act), .soft_reset_pulse(soft_reset_pulse));
  spc_host u_host (.clk(clk), .csb_n(csb_n), .sclk(sclk), .sdio_drv(sdio_drv),
    .sdio_out(sdio_in), .serial_out_pin(sdo_line),
    .pin_dir(pin_direction_select));
  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // register write and single byte read
  task automatic wr(input logic [12:0] a, input logic [15:0] d, input int nb,
                    input logic lsb);
    u_host.xfer({3'b000, a}, d, nb, lsb, rd);
  endtask
  task automatic rdr(input logic [12:0] a, input logic lsb);
    u_host.xfer({3'b100, a}, 16'h0000, 1, lsb, rd);
  endtask
  // defaults after reset
  task automatic t_reset;
    check(pin_direction_select, 8'h00);
    check(lsb_first_act, 8'h00);
    rdr(`SPC_OFS_CFG, 1'b0);
    check(rd[15:8], 8'h00);
  endtask
  // two bytes from 0x005 land on readback_bank_select
  task automatic t_msb_dec;
    wr(13'h0005, 16'hA501, 2, 1'b0);
    // select now points at the active copy, so copy it over first
    @(posedge clk) reg_update <= 1'b1;
    @(posedge clk) reg_update <= 1'b0;
    rdr(`SPC_OFS_RBS, 1'b0);
    check(rd[15:8], 8'h01);
  endtask
  // split pins: read on the separate output
  task automatic t_dir;
    wr(`SPC_OFS_CFG, 16'h8100, 1, 1'b0);
    check(pin_direction_select, 8'h01);
    rdr(`SPC_OFS_RBS, 1'b0);
    check(rd[15:8], 8'h01);
    wr(`SPC_OFS_CFG, 16'h0000, 1, 1'b0);
    check(pin_direction_select, 8'h00);
  endtask
  // lsb first, two bytes from 0x003 land on readback_bank_select
  task automatic t_lsb_inc;
    wr(`SPC_OFS_CFG, 16'h4200, 1, 1'b0);
    check(lsb_first_act, 8'h01);
    wr(13'h0003, 16'hA500, 2, 1'b1);
    rdr(`SPC_OFS_RBS, 1'b1);
    check(rd[15:8], 8'h00);
    rdr(`SPC_OFS_CFG, 1'b1);
    check(rd[15:8], 8'h42);
  endtask
  // i2c mode forces msb first, then readback of active copy
  task automatic t_i2c_rb;
    @(posedge clk) i2c_mode <= 1'b1;
    wr(13'h0005, 16'hA501, 2, 1'b0);
    rdr(`SPC_OFS_RBS, 1'b0);
    check(rd[15:8], 8'h01);
    @(posedge clk) i2c_mode <= 1'b0;
    // active config still holds the old copy, buffer holds 0x42
    rdr(`SPC_OFS_CFG, 1'b1);
    check(rd[15:8], 8'h00);
    @(posedge clk) reg_update <= 1'b1;
    @(posedge clk) reg_update <= 1'b0;
    rdr(`SPC_OFS_CFG, 1'b1);
    check(rd[15:8], 8'h42);
    rdr(`SPC_OFS_RBS, 1'b1);
    check(rd[15:8], 8'h01);
  endtask
  // soft reset written in lsb order
  task automatic t_srst;
    wr(`SPC_OFS_CFG, 16'h2400, 1, 1'b1);
    check(srst_seen, 8'h01);
    check(lsb_first_act, 8'h00);
    rdr(`SPC_OFS_CFG, 1'b0);
    check(rd[15:8], 8'h00);
    rdr(`SPC_OFS_RBS, 1'b0);
    check(rd[15:8], 8'h00);
  endtask
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_msb_dec;
    t_dir;
    t_lsb_inc;
    t_i2c_rb;
    t_srst;
    close_out;
  end
  // watchdog, about six times the expected run
  initial begin
    #400000;
    n_fail++;
    close_out;
  end
endmodule // tb_spc_serial_cfg
